// >>> two_wire_params.svh
// constants of the two-wire bus controller: queue depth, fields, resets, timing
// assumes the system clock period given below; included by the queue and controller files
`ifndef TWO_WIRE_PARAMS_SVH
`define TWO_WIRE_PARAMS_SVH

// ============================================================
// timing
`define CLK_NS        50
`define SS_HALF_NS    5000
`define FS_HALF_NS    1250
`define SS_HALF_CYC   ((`SS_HALF_NS + `CLK_NS - 1) / `CLK_NS)
`define FS_HALF_CYC   ((`FS_HALF_NS + `CLK_NS - 1) / `CLK_NS)

// ============================================================
// queue geometry and fields
`define FIFO_DEPTH    4
`define ENTRY_RD_BIT  8

// ============================================================
// addressing and resets
`define OWN_ADDR_RST  10'h055
`define TENBIT_HDR    5'h1E

// ============================================================
// event flag positions
`define INT_TXE       0
`define INT_RXA       1
`define INT_NACK      2

`endif

// >>> two_wire_pkg.sv
// types shared by the two-wire controller and its queue
// assumes nothing beyond a SystemVerilog compiler
package two_wire_pkg;

  // queue entry: direction flag over data byte
  typedef struct packed {
    logic       rd;
    logic [7:0] data;
  } entry_t;

  typedef logic [2:0] level_t;

  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_START  = 9'h002,
    S_LO     = 9'h004,
    S_HI     = 9'h008,
    S_LOAD   = 9'h010,
    S_STOP   = 9'h020,
    S_RSTART = 9'h040,
    S_SLV    = 9'h080,
    S_STX    = 9'h100
  } state_t;

endpackage : two_wire_pkg

// >>> entry_fifo.sv
// four-deep queue of nine-bit entries with valid/ready on both sides
// assumes both sides on sys_clk; ce freezes it
`timescale 1ns/100ps
`default_nettype none
`include "two_wire_params.svh"

module entry_fifo (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  input  wire logic                 wrValid,
  input  wire two_wire_pkg::entry_t wrData,
  output logic                      wrReady,
  output logic                      rdValid,
  output two_wire_pkg::entry_t      rdData,
  input  wire logic                 rdReady,
  output two_wire_pkg::level_t      level
);

  two_wire_pkg::entry_t mem [`FIFO_DEPTH];
  logic [1:0]           wrPtr_r;
  logic [1:0]           rdPtr_r;
  two_wire_pkg::level_t count_r;
  wire                  doWr;
  wire                  doRd;

  // ============================================================
  // handshakes: honest full and empty
  assign wrReady = (count_r != 3'(`FIFO_DEPTH));
  assign rdValid = (count_r != 3'h0);
  assign doWr    = wrValid & wrReady;
  assign doRd    = rdReady & rdValid;
  assign rdData  = mem[rdPtr_r];
  assign level   = count_r;

  // pointers wrap naturally at depth four
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= 2'h0;
      rdPtr_r <= 2'h0;
      count_r <= 3'h0;
    end else if (ce) begin
      if (doWr) wrPtr_r <= wrPtr_r + 2'h1;
      if (doRd) rdPtr_r <= rdPtr_r + 2'h1;
      count_r <= count_r + 3'(doWr) - 3'(doRd);
    end
  end

  // storage needs no reset; read side only looks at valid slots
  always_ff @(posedge sys_clk) begin
    if (ce && doWr) mem[wrPtr_r] <= wrData;
  end

endmodule : entry_fifo
`default_nettype wire

// >>> two_wire_bus_master.sv
// two-wire bus controller: master engine, read-slave stall, queues, flags
// assumes open-drain pads outside resolve the wired-AND and pull-ups exist
`timescale 1ns/100ps
`default_nettype none
`include "two_wire_params.svh"

module two_wire_bus_master (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  input  wire logic                 enable,
  input  wire logic                 restartEn,
  input  wire logic                 addr10,
  input  wire logic                 fastMode,
  input  wire logic [9:0]           tarAddr,
  input  wire logic [7:0]           sdaHold,
  input  wire logic                 ownAddrWe,
  input  wire logic [9:0]           ownAddrIn,
  output logic [9:0]                ownAddr,
  input  wire logic                 txWrValid,
  input  wire two_wire_pkg::entry_t txWrData,
  output logic                      txWrReady,
  output logic                      rxRdValid,
  output two_wire_pkg::entry_t      rxRdData,
  input  wire logic                 rxRdReady,
  output two_wire_pkg::level_t      txLevel,
  output two_wire_pkg::level_t      rxLevel,
  input  wire logic [2:0]           intMask,
  input  wire logic [2:0]           intClr,
  output logic [2:0]                intStat,
  output logic                      irq,
  output logic                      busBusy,
  input  wire logic                 sclIn,
  output logic                      sclO,
  output logic                      sclOe,
  input  wire logic                 sdaIn,
  output logic                      sdaO,
  output logic                      sdaOe
);

  // ============================================================
  // declarations
  two_wire_pkg::state_t state_r, state_nxt;
  logic [7:0]           cnt_r, cnt_nxt;
  logic [3:0]           bitIdx_r, bitIdx_nxt;
  logic [7:0]           shift_r, shift_nxt;
  logic [1:0]           stage_r, stage_nxt;
  logic                 sclOe_r, sclOe_nxt;
  logic                 sdaOe_r, sdaOe_nxt;
  logic                 dir_r, dir_nxt;
  logic                 ackOut_r, ackOut_nxt;
  logic                 sclS1_r, sclS2_r, sclD_r;
  logic                 sdaS1_r, sdaS2_r, sdaD_r;
  logic                 busy_r;
  logic [2:0]           intStat_r;
  logic                 irq_r;
  logic [9:0]           ownAddr_r;
  logic                 txPop, rxPush, nackEv;
  logic                 txValid, rxWrReady;
  two_wire_pkg::entry_t txHead, rxEntry;

  // ============================================================
  // queues
  entry_fifo txQueue (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .wrValid (txWrValid),
    .wrData  (txWrData),
    .wrReady (txWrReady),
    .rdValid (txValid),
    .rdData  (txHead),
    .rdReady (txPop),
    .level   (txLevel)
  );

  entry_fifo rxQueue (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .wrValid (rxPush),
    .wrData  (rxEntry),
    .wrReady (rxWrReady),
    .rdValid (rxRdValid),
    .rdData  (rxRdData),
    .rdReady (rxRdReady),
    .level   (rxLevel)
  );

  // ============================================================
  // line decode on the synchronised copies only
  wire       sclRise  = sclS2_r & ~sclD_r;
  wire       sclFall  = ~sclS2_r & sclD_r;
  // start and stop seen on the bus
  wire       startDet = sclS2_r & sclD_r & sdaD_r & ~sdaS2_r;
  wire       stopDet  = sclS2_r & sclD_r & ~sdaD_r & sdaS2_r;
  // half bit time per speed class
  wire [7:0] halfCnt  = fastMode ? 8'(`FS_HALF_CYC) : 8'(`SS_HALF_CYC);
  wire       halfDone = (cnt_r >= halfCnt - 8'h01);
  wire [7:0] cntInc   = cnt_r + 8'h01;
  // data placed once hold time has run
  wire       holdDone = (cnt_r == sdaHold) | halfDone;
  wire       byteRd   = (stage_r == 2'h2) & dir_r;
  // ack bit driven low on a read byte only when more entries are queued behind it
  wire       bitVal   = bitIdx_r[3] ? ~(byteRd & ackOut_r) : (byteRd | shift_r[7]);
  wire       ownMatch = (shift_r[7:1] == ownAddr_r[6:0]);
  // one address width per frame; addr10 must not move mid-frame
  wire [7:0] firstByte = addr10 ? {`TENBIT_HDR, tarAddr[9:8], txHead.rd} : {tarAddr[6:0], txHead.rd};
  wire [2:0] evSet;

  assign rxEntry = '{rd: ~ackOut_r, data: shift_r};

  // ============================================================
  // protocol engine next state
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    bitIdx_nxt = bitIdx_r;
    shift_nxt  = shift_r;
    stage_nxt  = stage_r;
    sclOe_nxt  = sclOe_r;
    sdaOe_nxt  = sdaOe_r;
    dir_nxt    = dir_r;
    ackOut_nxt = ackOut_r;
    txPop      = 1'b0;
    rxPush     = 1'b0;
    nackEv     = 1'b0;
    unique case (state_r)
      two_wire_pkg::S_IDLE: begin
        sclOe_nxt  = 1'b0;
        sdaOe_nxt  = 1'b0;
        cnt_nxt    = 8'h00;
        bitIdx_nxt = 4'h0;
        if (enable && startDet) begin
          state_nxt = two_wire_pkg::S_SLV;
        // queued entry starts only on a free bus
        end else if (enable && txValid && !busy_r && sclS2_r && sdaS2_r) begin
          state_nxt = two_wire_pkg::S_START;
        end
      end
      two_wire_pkg::S_START: begin
        if (bitIdx_r == 4'h0) begin
          // both lines must read high before the edge, even after a restart
          if (sclS2_r && sdaS2_r) cnt_nxt = cntInc;
          if (sclS2_r && sdaS2_r && halfDone) begin
            sdaOe_nxt  = 1'b1;
            cnt_nxt    = 8'h00;
            bitIdx_nxt = 4'h1;
          end
        end else begin
          cnt_nxt = cntInc;
          if (halfDone) begin
            sclOe_nxt  = 1'b1;
            cnt_nxt    = 8'h00;
            bitIdx_nxt = 4'h0;
            dir_nxt    = txHead.rd;
            shift_nxt  = firstByte;
            stage_nxt  = 2'h0;
            state_nxt  = two_wire_pkg::S_LO;
          end
        end
      end
      two_wire_pkg::S_LO: begin
        cnt_nxt = cntInc;
        // SDA moves only with SCL low
        if (holdDone) sdaOe_nxt = ~bitVal;
        if (halfDone) begin
          sclOe_nxt = 1'b0;
          cnt_nxt   = 8'h00;
          state_nxt = two_wire_pkg::S_HI;
        end
      end
      two_wire_pkg::S_HI: begin
        // a stretching slave pauses the count
        if (sclS2_r) cnt_nxt = cntInc;
        if (sclS2_r && halfDone) begin
          sclOe_nxt = 1'b1;
          cnt_nxt   = 8'h00;
          if (!bitIdx_r[3]) begin
            shift_nxt  = {shift_r[6:0], sdaS2_r};
            bitIdx_nxt = bitIdx_r + 4'h1;
            state_nxt  = two_wire_pkg::S_LO;
          end else begin
            bitIdx_nxt = 4'h0;
            rxPush     = byteRd;
            state_nxt  = two_wire_pkg::S_LOAD;
            if (!byteRd && sdaS2_r) begin
              nackEv    = 1'b1;
              txPop     = (stage_r != 2'h2) & txValid;
              state_nxt = two_wire_pkg::S_STOP;
            end
          end
        end
      end
      two_wire_pkg::S_LOAD: begin
        cnt_nxt = 8'h00;
        // second byte of a ten-bit address
        if (stage_r == 2'h0 && addr10) begin
          shift_nxt = tarAddr[7:0];
          stage_nxt = 2'h1;
          state_nxt = two_wire_pkg::S_LO;
        end else if (!txValid || !enable) begin
          state_nxt = two_wire_pkg::S_STOP;
        end else if (txHead.rd != dir_r) begin
          state_nxt = restartEn ? two_wire_pkg::S_RSTART : two_wire_pkg::S_STOP;
        // byte wait: SCL held low while the receive queue is full
        end else if (!txHead.rd || rxWrReady) begin
          txPop      = 1'b1;
          stage_nxt  = 2'h2;
          shift_nxt  = txHead.data;
          ackOut_nxt = (txLevel > 3'h1);
          state_nxt  = two_wire_pkg::S_LO;
        end
      end
      two_wire_pkg::S_STOP: begin
        if (bitIdx_r != 4'h1 || sclS2_r) cnt_nxt = cntInc;
        if (bitIdx_r == 4'h0) begin
          if (holdDone) sdaOe_nxt = 1'b1;
          if (halfDone) begin
            sclOe_nxt  = 1'b0;
            cnt_nxt    = 8'h00;
            bitIdx_nxt = 4'h1;
          end
        end else if (bitIdx_r == 4'h1) begin
          if (sclS2_r && halfDone) begin
            sdaOe_nxt  = 1'b0;
            cnt_nxt    = 8'h00;
            bitIdx_nxt = 4'h2;
          end
        end else if (halfDone) begin
          state_nxt = two_wire_pkg::S_IDLE;
        end
      end
      two_wire_pkg::S_RSTART: begin
        cnt_nxt = cntInc;
        if (holdDone) sdaOe_nxt = 1'b0;
        if (halfDone) begin
          sclOe_nxt  = 1'b0;
          cnt_nxt    = 8'h00;
          bitIdx_nxt = 4'h0;
          state_nxt  = two_wire_pkg::S_START;
        end
      end
      two_wire_pkg::S_SLV: begin
        if (stopDet || !enable) begin
          sclOe_nxt = 1'b0;
          sdaOe_nxt = 1'b0;
          state_nxt = two_wire_pkg::S_IDLE;
        end else if (sclRise && !bitIdx_r[3]) begin
          shift_nxt  = {shift_r[6:0], sdaS2_r};
          bitIdx_nxt = bitIdx_r + 4'h1;
        end else if (sclFall && bitIdx_r == 4'h8) begin
          sdaOe_nxt  = ownMatch & shift_r[0];
          bitIdx_nxt = 4'h9;
          if (!(ownMatch && shift_r[0])) state_nxt = two_wire_pkg::S_IDLE;
        end else if (sclFall && bitIdx_r == 4'h9) begin
          sdaOe_nxt = 1'b0;
          sclOe_nxt = 1'b1;
        end
        // stall with SCL low until data or disable
        if (sclOe_r && txValid) begin
          txPop      = 1'b1;
          shift_nxt  = txHead.data;
          sdaOe_nxt  = ~txHead.data[7];
          bitIdx_nxt = 4'h0;
          cnt_nxt    = 8'h00;
          state_nxt  = two_wire_pkg::S_STX;
        end
      end
      two_wire_pkg::S_STX: begin
        if (sclOe_r) begin
          cnt_nxt = cntInc;
          if (cnt_r >= sdaHold) sclOe_nxt = 1'b0;
        end else if (sclFall) begin
          shift_nxt  = {shift_r[6:0], 1'b1};
          bitIdx_nxt = bitIdx_r + 4'h1;
          sdaOe_nxt  = ~shift_r[6];
          if (bitIdx_r == 4'h7) begin
            sdaOe_nxt = 1'b0;
            state_nxt = two_wire_pkg::S_IDLE;
          end
        end
        if (!enable) begin
          sclOe_nxt = 1'b0;
          sdaOe_nxt = 1'b0;
          state_nxt = two_wire_pkg::S_IDLE;
        end
      end
    endcase
  end

  // ============================================================
  // engine registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r  <= two_wire_pkg::S_IDLE;
      cnt_r    <= 8'h00;
      bitIdx_r <= 4'h0;
      shift_r  <= 8'h00;
      stage_r  <= 2'h0;
      sclOe_r  <= 1'b0;
      sdaOe_r  <= 1'b0;
      dir_r    <= 1'b0;
      ackOut_r <= 1'b0;
    end else if (ce) begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      bitIdx_r <= bitIdx_nxt;
      shift_r  <= shift_nxt;
      stage_r  <= stage_nxt;
      sclOe_r  <= sclOe_nxt;
      sdaOe_r  <= sdaOe_nxt;
      dir_r    <= dir_nxt;
      ackOut_r <= ackOut_nxt;
    end
  end

  // two flops per pin, third flop only for edge finding
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {sclS1_r, sclS2_r, sclD_r} <= 3'h7;
      {sdaS1_r, sdaS2_r, sdaD_r} <= 3'h7;
    end else if (ce) begin
      {sclS1_r, sclS2_r, sclD_r} <= {sclIn, sclS1_r, sclS2_r};
      {sdaS1_r, sdaS2_r, sdaD_r} <= {sdaIn, sdaS1_r, sdaS2_r};
    end
  end

  // ============================================================
  // busy flag, event flags, own address
  // set beats a clear in the same cycle
  assign evSet[`INT_TXE]  = ~txValid;
  assign evSet[`INT_RXA]  = rxPush;
  assign evSet[`INT_NACK] = nackEv;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_r    <= 1'b0;
      intStat_r <= 3'h0;
      irq_r     <= 1'b0;
      ownAddr_r <= `OWN_ADDR_RST;
    end else if (ce) begin
      busy_r    <= startDet | (busy_r & ~stopDet);
      intStat_r <= evSet | (intStat_r & ~intClr);
      irq_r     <= |(intStat_r & intMask);
      // reset value above, software may override
      if (ownAddrWe) ownAddr_r <= ownAddrIn;
    end
  end

  // ============================================================
  // outputs
  // pads only ever pull low
  assign sclO    = 1'b0;
  assign sdaO    = 1'b0;
  assign sclOe   = sclOe_r;
  assign sdaOe   = sdaOe_r;
  assign busBusy = busy_r;
  assign intStat = intStat_r;
  assign irq     = irq_r;
  assign ownAddr = ownAddr_r;

endmodule : two_wire_bus_master
`default_nettype wire

// >>> two_wire_bus_master_sva.sv
// checker for the two-wire controller: line order, hold time, queue and busy relations
// assumes sclIn and sdaIn carry the resolved wired-AND line levels
`timescale 1ns/100ps
`default_nettype none
module two_wire_bus_master_sva (
  input wire logic                 sys_clk,
  input wire logic                 resetn,
  input wire logic                 enable,
  input wire logic [7:0]           sdaHold,
  input wire logic [9:0]           ownAddr,
  input wire logic                 txWrReady,
  input wire two_wire_pkg::level_t txLevel,
  input wire logic [2:0]           intStat,
  input wire logic                 busBusy,
  input wire logic                 sclIn,
  input wire logic                 sclO,
  input wire logic                 sclOe,
  input wire logic                 sdaIn,
  input wire logic                 sdaO,
  input wire logic                 sdaOe
);
  localparam int WAIT_MAX = 300;
  logic [7:0] lowCnt_r;
  // ============================================================
  // helper: cycles since we pulled SCL low, saturating so a long stall cannot wrap
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) lowCnt_r <= 8'h00;
    else if (!sclOe) lowCnt_r <= 8'h00;
    else if (lowCnt_r != 8'hFF) lowCnt_r <= lowCnt_r + 8'h01;
  end
  // ============================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence startSeq; $rose(sdaOe) && !sclOe; endsequence
  sequence stopSeq; $fell(sdaOe) && !sclOe; endsequence
  a_fifo_refuse: assert property (txWrReady == (txLevel != 3'h4))
    else $error("tx ready disagrees with level");
  a_own_reset: assert property (!$past(resetn) |-> ownAddr == 10'h055)
    else $error("own address not at default");
  a_start_prompt: assert property (enable && txLevel != 3'h0 && !busBusy && sclIn && sdaIn && !sdaOe
    |-> ##[1:WAIT_MAX] startSeq) else $error("queued entry gave no start");
  a_sda_scl_order: assert property ($changed(sdaOe) && !sclOe |-> sclIn && $past(sclIn))
    else $error("sda moved as scl was released");
  a_open_drain: assert property (sclO == 1'b0 && sdaO == 1'b0)
    else $error("line driven high");
  a_busy_start: assert property (startSeq |-> ##[1:6] busBusy)
    else $error("start did not mark bus busy");
  a_busy_clocking: assert property (sclOe |-> busBusy)
    else $error("clocking while bus free");
  a_stop_frees: assert property (stopSeq |-> ##[1:6] !busBusy)
    else $error("stop did not free bus");
  a_hold_time: assert property ($changed(sdaOe) && sclOe |-> {1'b0, lowCnt_r} + 9'h001 >= {1'b0, sdaHold})
    else $error("sda changed inside hold");
  a_nack_stop: assert property ($rose(intStat[2]) |-> ##[0:WAIT_MAX] stopSeq)
    else $error("missing ack without stop");
endmodule : two_wire_bus_master_sva

bind two_wire_bus_master two_wire_bus_master_sva chk_u (
  .sys_clk(sys_clk), .resetn(resetn), .enable(enable), .sdaHold(sdaHold), .ownAddr(ownAddr),
  .txWrReady(txWrReady), .txLevel(txLevel), .intStat(intStat), .busBusy(busBusy), .sclIn(sclIn),
  .sclO(sclO), .sclOe(sclOe), .sdaIn(sdaIn), .sdaO(sdaO), .sdaOe(sdaOe)
);
`default_nettype wire

// >>> bus_slave_model.sv
// behavioural slave on the two lines: acks its address, logs written bytes, sends a pattern on reads
// assumes the bench resolves the wired-AND with pull-ups and feeds both lines back
`timescale 1ns/100ps
`default_nettype none
module bus_slave_model #(
  parameter logic [6:0] SLV_ADDR = 7'h50
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sdaPull
);
  int         starts = 0;
  int         stops = 0;
  int         bitCnt = 0;
  int         rdCnt = 0;
  logic [7:0] rxLog[$];
  logic [7:0] shift, txByte;
  logic       inFrame = 1'b0;
  logic       firstByte, matched, reading, masterAck;
  initial sdaPull = 1'b0;
  // ============================================================
  // frame edges: only seen while scl is high
  always @(negedge sda) if (scl === 1'b1) begin
    starts++; inFrame = 1'b1; bitCnt = 0; rdCnt = 0;
    firstByte = 1'b1; matched = 1'b0; reading = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    stops++; inFrame = 1'b0; sdaPull = 1'b0;
  end
  // bits are taken on scl rise
  always @(posedge scl) if (inFrame) begin
    if (bitCnt < 8) shift = {shift[6:0], sda};
    else masterAck = !sda;
    bitCnt++;
  end
  // only changes sda while scl low, pull or release
  always @(negedge scl) if (inFrame) begin
    if (bitCnt == 8) begin
      if (!reading) rxLog.push_back(shift);
      if (firstByte) begin
        matched = (shift[7:1] == SLV_ADDR) || (shift[7:3] == 5'h1E);
        reading = matched && shift[0];
      end
      sdaPull = matched && (firstByte || !reading);
    end else if (bitCnt == 9) begin
      bitCnt = 0;
      sdaPull = 1'b0;
      if (reading && (firstByte || masterAck)) begin
        txByte = 8'hA5 ^ {8{rdCnt[0]}};
        rdCnt++;
        sdaPull = !txByte[7];
      end else reading = 1'b0;
      firstByte = 1'b0;
    end else if (reading && bitCnt < 8) sdaPull = !txByte[7-bitCnt];
  end
endmodule : bus_slave_model
`default_nettype wire

// >>> two_wire_bus_master_bench.sv
// bench for the two-wire controller: queue limit, writes, reads, combined formats, ten-bit, missing ack
// assumes the slave model at 0x50, pull-ups on both lines and the checker bind
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH %0t %s", $time, msg); end end
module two_wire_bus_master_bench;
  logic                 sys_clk = 1'b0, resetn = 1'b0, ce = 1'b1, fastMode = 1'b1;
  logic                 enable = 1'b1, restartEn = 1'b0, addr10 = 1'b0, ownAddrWe = 1'b0;
  logic                 txWrValid = 1'b0, rxRdReady = 1'b0;
  logic [9:0]           tarAddr = 10'h050, ownAddrIn = 10'h000, ownAddr;
  logic [7:0]           sdaHold = 8'h05;
  logic [2:0]           intMask = 3'h4, intClr = 3'h0, intStat;
  two_wire_pkg::entry_t txWrData = '0, rxRdData;
  two_wire_pkg::level_t txLevel, rxLevel;
  logic                 txWrReady, rxRdValid, irq, busBusy, sclO, sclOe, sdaO, sdaOe, sdaPull;
  wire logic            sclLine, sdaLine;
  int                   miscompares = 0, total_checks = 0, s0, p0;
  // ============================================================
  // wired-AND with pull-ups: a released line reads high
  assign sclLine = !sclOe;
  assign sdaLine = !(sdaOe || sdaPull);
  always #25 sys_clk = ~sys_clk;
  two_wire_bus_master dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .enable(enable), .restartEn(restartEn), .addr10(addr10),
    .fastMode(fastMode), .tarAddr(tarAddr), .sdaHold(sdaHold), .ownAddrWe(ownAddrWe), .ownAddrIn(ownAddrIn),
    .ownAddr(ownAddr), .txWrValid(txWrValid), .txWrData(txWrData), .txWrReady(txWrReady),
    .rxRdValid(rxRdValid), .rxRdData(rxRdData), .rxRdReady(rxRdReady), .txLevel(txLevel), .rxLevel(rxLevel),
    .intMask(intMask), .intClr(intClr), .intStat(intStat), .irq(irq), .busBusy(busBusy), .sclIn(sclLine),
    .sclO(sclO), .sclOe(sclOe), .sdaIn(sdaLine), .sdaO(sdaO), .sdaOe(sdaOe)
  );
  bus_slave_model #(.SLV_ADDR(7'h50)) slv_u (.scl(sclLine), .sda(sdaLine), .sdaPull(sdaPull));
  // ============================================================
  // shared drivers; inputs move 5 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : tick
  // one entry per call; a spare cycle keeps valid from toggling twice in one step
  task automatic push(input logic rd, input logic [7:0] data);
    txWrValid = 1'b1;
    txWrData = {rd, data};
    tick(1);
    txWrValid = 1'b0;
    tick(1);
  endtask : push
  task automatic waitDone();
    int n;
    n = 0;
    while (busBusy !== 1'b1 && n < 4000) begin tick(1); n++; end
    while ((busBusy !== 1'b0 || txLevel !== 3'h0) && n < 40000) begin tick(1); n++; end
    `CHK(n < 40000, 1'b1, "transfer hang")
    tick(60);
    s0 = slv_u.starts - s0;
    p0 = slv_u.stops - p0;
  endtask : waitDone
  task automatic mark();
    s0 = slv_u.starts;
    p0 = slv_u.stops;
  endtask : mark
  task automatic popRx(input two_wire_pkg::entry_t exp);
    `CHK(rxRdValid, 1'b1, "rx empty")
    `CHK(rxRdData, exp, "rx entry")
    rxRdReady = 1'b1;
    tick(1);
    rxRdReady = 1'b0;
    tick(1);
  endtask : popRx
  task automatic checkLog(input logic [7:0] exp[$]);
    `CHK(slv_u.rxLog.size(), exp.size(), "byte count")
    foreach (exp[i]) if (i < slv_u.rxLog.size()) `CHK(slv_u.rxLog[i], exp[i], "bus byte")
    slv_u.rxLog.delete();
  endtask : checkLog
  // ============================================================
  // scenarios
  task automatic testReset();
    `CHK(ownAddr, 10'h055, "own address default")
    `CHK(busBusy, 1'b0, "busy after reset")
    `CHK(intStat[0], 1'b1, "tx empty flag")
    $display("reset test done");
  endtask : testReset
  task automatic testWriteFull();
    enable = 1'b0;
    mark();
    ce = 1'b0;
    push(1'b0, 8'hEE);
    `CHK(txLevel, 3'h0, "frozen queue took entry")
    ce = 1'b1;
    for (int i = 1; i <= 4; i++) push(1'b0, 8'(8'h11 * i));
    `CHK(txLevel, 3'h4, "tx level full")
    `CHK(txWrReady, 1'b0, "full queue refuses")
    enable = 1'b1;
    waitDone();
    checkLog('{8'hA0, 8'h11, 8'h22, 8'h33, 8'h44});
    `CHK(s0, 1, "one start")
    `CHK(p0, 1, "one stop")
    $display("write test done");
  endtask : testWriteFull
  task automatic testRead();
    mark();
    push(1'b1, 8'h00);
    push(1'b1, 8'h00);
    waitDone();
    checkLog('{8'hA1});
    `CHK(rxLevel, 3'h2, "rx level")
    popRx({1'b0, 8'hA5});
    popRx({1'b1, 8'h5A});
    $display("read test done");
  endtask : testRead
  task automatic testNack();
    tarAddr = 10'h033;
    mark();
    push(1'b0, 8'h99);
    waitDone();
    checkLog('{8'h66});
    `CHK(intStat[2], 1'b1, "missing ack flag")
    `CHK(p0, 1, "abort stop")
    `CHK(irq, 1'b1, "unmasked irq")
    intClr = 3'h4;
    tick(1);
    intClr = 3'h0;
    tick(2);
    `CHK(intStat[2], 1'b0, "flag cleared")
    `CHK(irq, 1'b0, "irq cleared")
    tarAddr = 10'h050;
    $display("missing ack test done");
  endtask : testNack
  task automatic testCombined();
    for (int re = 0; re < 2; re++) begin
      restartEn = re[0];
      enable = 1'b0;
      mark();
      push(1'b0, 8'h77);
      push(1'b1, 8'h00);
      enable = 1'b1;
      waitDone();
      checkLog('{8'hA0, 8'h77, 8'hA1});
      `CHK(s0, 2, "starts in combined")
      `CHK(p0, (re == 1) ? 1 : 2, "stops in combined")
      popRx({1'b1, 8'hA5});
    end
    $display("combined test done");
  endtask : testCombined
  task automatic testTenBit();
    addr10 = 1'b1;
    tarAddr = 10'h2B5;
    sdaHold = 8'h03;
    fastMode = 1'b0;
    mark();
    push(1'b0, 8'h3C);
    waitDone();
    checkLog('{8'hF4, 8'hB5, 8'h3C});
    `CHK(p0, 1, "ten-bit stop")
    fastMode = 1'b1;
    addr10 = 1'b0;
    tarAddr = 10'h050;
    $display("ten-bit test done");
  endtask : testTenBit
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  // ============================================================
  // main sequence and watchdog
  initial begin
    tick(12);
    resetn = 1'b1;
    tick(3);
    testReset();
    testWriteFull();
    testRead();
    testNack();
    testCombined();
    testTenBit();
    summarize();
  end
  initial begin
    #(50 * 100000);
    miscompares++;
    summarize();
  end
endmodule : two_wire_bus_master_bench
`default_nettype wire
